// ---- ebt_bus_seq.sv ----
// External bus cycle sequencer with programmable waitstates
`default_nettype none

module ebt_bus_seq
    import ebt_pkg::*;
#(
    parameter int NREG = NUM_REGIONS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire ebt_req_s req,
    input wire ebt_cfg_s bus_region_config [NREG],
    input wire logic ready_n,
    input wire logic [DATA_W-1:0] ad_in,
    output logic bus_reference_clock,
    output logic [ADDR_W-1:0] address,
    output logic byte_high_enable_n,
    output logic ale,
    output logic read_n,
    output logic write_n,
    output logic write_high_byte_n,
    output logic write_low_byte_n,
    output logic [NREG-1:0] write_chip_select_n,
    output logic [NREG-1:0] cs_early_n,
    output logic [NREG-1:0] cs_latched_n,
    output logic [DATA_W-1:0] ad_out,
    output logic ad_oe_n,
    output logic req_accept,
    output logic cycle_done,
    output logic [DATA_W-1:0] read_data
);

    initial begin
        if (NREG < 1 || NREG > (1 << REGION_W)) begin
            $error("ebt_bus_seq: NREG out of range");
        end
        if (TCL_CLOCKS != 1) begin
            $error("ebt_bus_seq: half-period must be one clock");
        end
    end

    ebt_state_e state_q;
    ebt_state_e state_d;
    ebt_cfg_s cfg_q;
    ebt_cfg_s cfg_sel;
    ebt_req_s req_q;
    logic ref_q;
    logic addr_left_q;
    logic ready_hi_q;
    logic ready_s;
    logic wait_zero;
    logic fall;
    logic cmd_done;
    logic cycle_end;
    logic start;
    logic strobe_go;
    logic strobe_end;
    logic [NREG-1:0] cs_sel;
    logic [7:0] len_q;
    logic [7:0] ws_tcl;

    // Edge that takes the reference clock low
    assign fall = ref_q;

    ebt_sync #(
        .RESET_VAL(READY_RESET)
    ) u_ready_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din(ready_n),
        .level_q(ready_s)
    );

    ebt_wait_cnt #(
        .W(MCTC_W)
    ) u_cmd_wait (
        .clock(clock),
        .rst_n(rst_n),
        .load(start),
        .load_val(MCTC_MAX - cfg_sel.mctc),
        .dec(state_q == ST_CMD && fall),
        .zero(wait_zero)
    );

    // Region configuration and select vector for a new request
    always_comb begin
        cs_sel = '1;
        cfg_sel = bus_region_config[0];
        if (32'(req.region) < NREG) begin
            cfg_sel = bus_region_config[req.region];
            cs_sel[req.region] = 1'b0;
        end
    end

    // Command phase ends on a falling edge after waits and ready
    assign cmd_done = wait_zero && !(cfg_q.ready_en && ready_hi_q);

    always_comb begin
        cycle_end = 1'b0;
        if (fall) begin
            case (state_q)
                ST_CMD: cycle_end = cmd_done && !cfg_q.mux && cfg_q.mttc;
                ST_MUXW: cycle_end = cfg_q.mttc;
                ST_TRIS: cycle_end = 1'b1;
                default: cycle_end = 1'b0;
            endcase
        end
    end

    assign start = fall && req_valid && (state_q == ST_IDLE || cycle_end);
    assign strobe_go = (state_q == ST_ADDR && fall && !addr_left_q &&
                        cfg_q.read_write_delay_select) ||
                       (state_q == ST_CMD && !fall);
    assign strobe_end = state_q == ST_CMD && fall && cmd_done;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (fall && !addr_left_q) begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (strobe_end) begin
                    if (cfg_q.mux) begin
                        state_d = ST_MUXW;
                    end else if (!cfg_q.mttc) begin
                        state_d = ST_TRIS;
                    end else begin
                        state_d = start ? ST_ADDR : ST_IDLE;
                    end
                end
            end
            ST_MUXW: begin
                if (fall) begin
                    if (!cfg_q.mttc) begin
                        state_d = ST_TRIS;
                    end else begin
                        state_d = start ? ST_ADDR : ST_IDLE;
                    end
                end
            end
            ST_TRIS: begin
                if (fall) begin
                    state_d = start ? ST_ADDR : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Reference clock toggles every half-period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_q <= REF_RESET;
        end else begin
            ref_q <= !ref_q;
        end
    end

    // Request capture and handshake
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_q <= '0;
            req_q <= '0;
            req_accept <= 1'b0;
            cycle_done <= 1'b0;
            addr_left_q <= 1'b0;
        end else begin
            req_accept <= start;
            cycle_done <= cycle_end;
            if (start) begin
                cfg_q <= cfg_sel;
                req_q <= req;
                addr_left_q <= cfg_sel.ale_ext;
            end else if (state_q == ST_ADDR && fall) begin
                addr_left_q <= 1'b0;
            end
        end
    end

    // Ready sampled at the rising reference edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_hi_q <= READY_RESET;
        end else if (!fall) begin
            ready_hi_q <= ready_s;
        end
    end

    // Address, byte enable and early selects move on falling edges
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            address <= '0;
            byte_high_enable_n <= STROBE_IDLE;
            cs_early_n <= '1;
        end else if (start) begin
            address <= req.addr;
            byte_high_enable_n <= !req.be[1];
            cs_early_n <= cs_sel;
        end else if (cycle_end) begin
            cs_early_n <= '1;
        end
    end

    // Latch strobe rises on falling edge, drops on rising edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ale <= 1'b0;
            cs_latched_n <= '1;
        end else if (start) begin
            ale <= 1'b1;
        end else if (state_q == ST_ADDR && !fall && !addr_left_q) begin
            ale <= 1'b0;
            cs_latched_n <= cs_of(req_q.region);
        end else if (state_q == ST_IDLE && !fall) begin
            cs_latched_n <= '1;
        end
    end

    function automatic logic [NREG-1:0] cs_of(input logic [REGION_W-1:0] r);
        logic [NREG-1:0] v;
        v = '1;
        if (32'(r) < NREG) begin
            v[r] = 1'b0;
        end
        return v;
    endfunction : cs_of

    // Read and write strobes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            read_n <= STROBE_IDLE;
            write_n <= STROBE_IDLE;
            write_high_byte_n <= STROBE_IDLE;
            write_low_byte_n <= STROBE_IDLE;
            write_chip_select_n <= '1;
        end else if (strobe_end) begin
            read_n <= STROBE_IDLE;
            write_n <= STROBE_IDLE;
            write_high_byte_n <= STROBE_IDLE;
            write_low_byte_n <= STROBE_IDLE;
            write_chip_select_n <= '1;
        end else if (strobe_go) begin
            read_n <= req_q.write;
            write_n <= !req_q.write;
            write_high_byte_n <= !(req_q.write && req_q.be[1]);
            write_low_byte_n <= !(req_q.write && req_q.be[0]);
            write_chip_select_n <= req_q.write ? cs_of(req_q.region) : '1;
        end
    end

    // Shared address/data lines and read data capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ad_out <= '0;
            ad_oe_n <= 1'b1;
            read_data <= '0;
        end else begin
            if (strobe_end) begin
                ad_oe_n <= 1'b1;
                if (!req_q.write) begin
                    read_data <= ad_in;
                end
            end else if (state_q == ST_ADDR && fall && !addr_left_q &&
                         cfg_q.mux) begin
                ad_out <= req_q.wdata;
                ad_oe_n <= !req_q.write;
            end
            if (start) begin
                if (cfg_sel.mux) begin
                    ad_out <= req.addr[DATA_W-1:0];
                    ad_oe_n <= 1'b0;
                end else begin
                    ad_out <= req.wdata;
                    ad_oe_n <= !req.write;
                end
            end
        end
    end

    assign bus_reference_clock = ref_q;

    // Cycle length observation for the checks below
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            len_q <= '0;
        end else if (start) begin
            len_q <= 8'h01;
        end else if (state_q != ST_IDLE) begin
            len_q <= len_q + 8'h01;
        end
    end

    assign ws_tcl = {3'h0, MCTC_MAX - cfg_q.mctc, 1'b0} +
                    {6'h00, !cfg_q.mttc, 1'b0};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_end_plain;
        state_q != ST_IDLE && cycle_end && !cfg_q.ready_en;
    endsequence

    sequence s_cmd_exit_mux;
        strobe_end && cfg_q.mux;
    endsequence

    a_len_demux_norm: assert property (
        s_end_plain and (!cfg_q.mux && !cfg_q.ale_ext)
        |-> len_q == BASE_DEMUX_NORM + ws_tcl)
        else $error("demux normal cycle length wrong");
    a_len_demux_ext: assert property (
        s_end_plain and (!cfg_q.mux && cfg_q.ale_ext)
        |-> len_q == BASE_DEMUX_EXT + ws_tcl)
        else $error("demux extended cycle length wrong");
    a_len_mux_norm: assert property (
        s_end_plain and (cfg_q.mux && !cfg_q.ale_ext)
        |-> len_q == BASE_MUX_NORM + ws_tcl)
        else $error("mux normal cycle length wrong");
    a_len_mux_ext: assert property (
        s_end_plain and (cfg_q.mux && cfg_q.ale_ext)
        |-> len_q == BASE_MUX_EXT + ws_tcl)
        else $error("mux extended cycle length wrong");
    a_ref_period: assert property (
        ##1 1 |-> bus_reference_clock != $past(bus_reference_clock)
        ##2 bus_reference_clock == $past(bus_reference_clock, 2))
        else $error("reference clock period wrong");
    a_ale_rise: assert property ($rose(ale) |-> $fell(ref_q))
        else $error("latch strobe rose off falling edge");
    a_ale_fall: assert property (
        $fell(ale) |-> $rose(ref_q) &&
        (cs_latched_n != '1 || 32'(req_q.region) >= NREG))
        else $error("latch strobe fell off rising edge");
    a_strobe_edge: assert property (
        $fell(read_n) || $fell(write_n)
        |-> (cfg_q.read_write_delay_select ? $fell(ref_q) : $rose(ref_q)))
        else $error("strobe asserted on wrong edge");
    a_read_latch: assert property (
        $rose(read_n) |-> $fell(ref_q) && read_data == $past(ad_in))
        else $error("read data not latched as read rose");
    a_addr_hold: assert property ($changed(address) |-> write_n)
        else $error("address changed while write active");
    a_lane_delay: assert property (
        $fell(write_high_byte_n) || $fell(write_low_byte_n)
        |-> $fell(write_n))
        else $error("byte write strobe off the write edge");
    a_cmd_wait: assert property (
        state_q == ST_CMD && fall && !wait_zero |=> state_q == ST_CMD [*2])
        else $error("command waitstate not inserted");
    a_tris_wait: assert property (
        strobe_end && !cfg_q.mux && !cfg_q.mttc
        |=> state_q == ST_TRIS [*2])
        else $error("tri-state waitstate not inserted");
    a_ready_wait: assert property (
        state_q == ST_CMD && fall && wait_zero && cfg_q.ready_en
        && ready_hi_q |=> !read_n || !write_n)
        else $error("ready high did not extend cycle");
    a_mux_wait: assert property (
        s_cmd_exit_mux |=> state_q == ST_MUXW [*2])
        else $error("mux waitstate missing");
    a_mux_addr: assert property (
        cfg_q.mux && state_q == ST_ADDR && !req_accept
        |-> !ad_oe_n && ad_out == address[DATA_W-1:0])
        else $error("mux address not on shared lines");

endmodule : ebt_bus_seq

`default_nettype wire

// ---- ebt_bus_seq_tb.sv ----
// Self-checking bench for the external bus sequencer
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module ebt_bus_seq_tb
    import ebt_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, lclk;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    ebt_req_s req = '0;
    ebt_cfg_s cfg [NUM_REGIONS];
    logic [3:0] stall = 4'h0;
    logic ready_n, bus_reference_clock, byte_high_enable_n;
    logic read_n, write_n, ad_oe_n, req_accept, cycle_done, ale;
    logic [DATA_W-1:0] ad_in, ad_out, read_data, wr_q;
    logic [ADDR_W-1:0] address;
    logic [NUM_REGIONS-1:0] cs_early_n;
    logic write_high_byte_n, write_low_byte_n;
    logic [NUM_REGIONS-1:0] write_chip_select_n, cs_latched_n;
    int seed = 32'hfc47;
    int err_total = 0;
    int n_tests = 0;

    ebt_bus_seq u_ebt_bus_seq (
        .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .bus_region_config(cfg), .ready_n(ready_n), .ad_in(ad_in),
        .bus_reference_clock(bus_reference_clock), .address(address),
        .byte_high_enable_n(byte_high_enable_n), .ale(ale),
        .read_n(read_n), .write_n(write_n),
        .write_high_byte_n(write_high_byte_n),
        .write_low_byte_n(write_low_byte_n),
        .write_chip_select_n(write_chip_select_n),
        .cs_early_n(cs_early_n), .cs_latched_n(cs_latched_n),
        .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .req_accept(req_accept),
        .cycle_done(cycle_done), .read_data(read_data)
    );

    ebt_mem_model u_ebt_mem_model (
        .clock(clock), .lclk(lclk), .address(address), .read_n(read_n),
        .write_n(write_n), .ad_out(ad_out), .stall(stall), .ad_in(ad_in),
        .ready_n(ready_n), .wr_q(wr_q)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        lclk = 1'b0;
        #13;
        forever #40 lclk = ~lclk;
    end

    function automatic int exp_len(input ebt_cfg_s c);
        int base;
        base = c.mux ? (c.ale_ext ? 8 : 6) : (c.ale_ext ? 6 : 4);
        return base + 2 * (15 - int'(c.mctc)) + 2 * (1 - int'(c.mttc));
    endfunction : exp_len

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // One access through the whole cycle; starts and ends at a falling edge
    task automatic xfer(input ebt_cfg_s c, input logic wr,
                        input logic [2:0] rg, input logic slow);
        ebt_req_s r;
        int n;
        logic seen;
        logic prev;
        logic dly;
        logic [4:0] cs_x;
        dly = c.read_write_delay_select;
        cs_x = (rg < 3'h5) ? ~(5'h01 << rg) : 5'h1F;
        r.addr = 24'($random(seed));
        r.wdata = 16'($random(seed));
        r.be = 2'($random(seed));
        r.write = wr;
        r.region = rg;
        for (int k = 0; k < NUM_REGIONS; k++) begin
            cfg[k] = c;
        end
        stall = slow ? 4'h3 : 4'h0;
        req = r;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (req_accept !== 1'b1 && n < 100);
        req_valid = 1'b0;
        `CHK("accept", 1'b1, req_accept)
        `CHK("ale_rise", 1'b1, ale)
        `CHK("address", r.addr, address)
        `CHK("bhe_n", !r.be[1], byte_high_enable_n)
        `CHK("cs_early", cs_x, cs_early_n)
        if (c.mux) begin
            `CHK("mux_addr", {1'b0, r.addr[15:0]}, {ad_oe_n, ad_out})
        end
        n = 0;
        seen = 1'b0;
        prev = bus_reference_clock;
        do begin
            @(negedge clock);
            n++;
            `CHK("ref_toggle", !prev, bus_reference_clock)
            prev = bus_reference_clock;
            if (!(read_n && write_n) && !seen) begin
                seen = 1'b1;
                `CHK("strobe_edge", !dly, bus_reference_clock)
                `CHK("wr_hi", !(wr && r.be[1]), write_high_byte_n)
                `CHK("wr_lo", !(wr && r.be[0]), write_low_byte_n)
                `CHK("wr_cs", wr ? cs_x : 5'h1F, write_chip_select_n)
                `CHK("cs_latched", cs_x, cs_latched_n)
            end
            if (!write_n) begin
                `CHK("addr_hold", r.addr, address)
            end
        end while (cycle_done !== 1'b1 && n < 400);
        `CHK("done", 1'b1, cycle_done)
        if (slow && c.ready_en) begin
            `CHK("ready_wait", 1'b1, n > exp_len(c))
        end else begin
            `CHK("length", exp_len(c), n)
        end
        if (wr) begin
            `CHK("wdata", r.wdata, wr_q)
        end else begin
            `CHK("rdata", r.addr[15:0] ^ 16'hC3A5, read_data)
        end
        $display("access done mode %b%b%b%b len %0d", c.mux, c.ale_ext,
                 c.read_write_delay_select, c.mttc, n);
    endtask : xfer

    initial begin
        ebt_cfg_s c;
        c = '0;
        for (int k = 0; k < NUM_REGIONS; k++) begin
            cfg[k] = '0;
        end
        repeat (20) @(negedge clock);
        `CHK("reset_idle", 3'b110, {read_n, write_n, ale})
        rst_n = 1'b1;
        for (int i = 0; i < 32; i++) begin
            c.mux = i[0];
            c.ale_ext = i[1];
            c.read_write_delay_select = i[2];
            c.mttc = i[3];
            c.mctc = 4'hC + 4'($random(seed) & 3);
            c.ready_en = 1'b0;
            xfer(c, i[4], 3'((($random(seed)) & 32'h7FFF) % 5), i[1]);
        end
        c.mctc = 4'h0;
        xfer(c, 1'b1, 3'h5, 1'b0);
        c.mctc = 4'hF;
        c.ready_en = 1'b1;
        xfer(c, 1'b0, 3'h2, 1'b1);
        c.mux = 1'b1;
        xfer(c, 1'b1, 3'h4, 1'b1);
        give_verdict;
    end

    initial begin
        #300000;
        err_total++;
        $display("BAD watchdog exp 0 got 1");
        give_verdict;
    end

endmodule : ebt_bus_seq_tb

`default_nettype wire

// ---- ebt_mem_model.sv ----
// Behavioural memory and peripheral on the far side of the external bus
`default_nettype none

module ebt_mem_model
    import ebt_pkg::*;
(
    input wire logic clock,
    input wire logic lclk,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [DATA_W-1:0] ad_out,
    input wire logic [3:0] stall,
    output logic [DATA_W-1:0] ad_in,
    output logic ready_n,
    output logic [DATA_W-1:0] wr_q
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] junk_q = 16'h5A5A;
    logic [3:0] cnt_q = 4'h0;
    logic idle;

    assign idle = read_n && write_n;

    // Data only while read is low, a toggling pattern otherwise
    assign ad_in = !read_n ? (address[15:0] ^ 16'hC3A5) : junk_q;

    always @(posedge clock) begin
        junk_q <= ~junk_q;
        if (!write_n) begin
            wr_q <= ad_out;
        end
    end

    // Ready inactive between cycles, active after stall link ticks
    always @(posedge lclk or posedge idle) begin
        if (idle) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Ready withdrawn as soon as the strobes rise, before the next sample
    assign ready_n = idle || (cnt_q < stall);

endmodule : ebt_mem_model

`default_nettype wire

// ---- ebt_pkg.sv ----
// Constants, states and carriers shared by the external bus sequencer
`default_nettype none

package ebt_pkg;

    // Timing: one clock_half_period per clock
    localparam int CLK_NS = 10;
    localparam int TCL_NS = 10;
    localparam int TCL_CLOCKS = (TCL_NS + CLK_NS - 1) / CLK_NS;

    // Widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REGION_W = 3;
    localparam int NUM_REGIONS = 5;
    localparam int MCTC_W = 4;

    // Waitstate field limits
    localparam logic [3:0] MCTC_MAX = 4'hF;

    // Phase lengths in clock_half_period units
    localparam logic [7:0] BASE_DEMUX_NORM = 8'h04;
    localparam logic [7:0] BASE_DEMUX_EXT = 8'h06;
    localparam logic [7:0] BASE_MUX_NORM = 8'h06;
    localparam logic [7:0] BASE_MUX_EXT = 8'h08;

    // Reset values
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic REF_RESET = 1'b1;
    localparam logic READY_RESET = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_MUXW,
        ST_TRIS
    } ebt_state_e;

    // One bus_region_config entry
    typedef struct packed {
        logic mux;
        logic ale_ext;
        logic read_write_delay_select;
        logic [MCTC_W-1:0] mctc;
        logic mttc;
        logic ready_en;
    } ebt_cfg_s;

    // One bus access request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic [1:0] be;
        logic [REGION_W-1:0] region;
    } ebt_req_s;

endpackage : ebt_pkg

`default_nettype wire

// ---- ebt_sync.sv ----
// Three-stage synchroniser for an asynchronous level input
`default_nettype none

module ebt_sync
    import ebt_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic din,
    output logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Change accepted once stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule : ebt_sync

`default_nettype wire

// ---- ebt_wait_cnt.sv ----
// Loadable down counter for command waitstates
`default_nettype none

module ebt_wait_cnt
    import ebt_pkg::*;
#(
    parameter int W = MCTC_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic dec,
    output logic zero
);

    logic [W-1:0] cnt_q;

    initial begin
        if (W < 1) begin
            $error("ebt_wait_cnt: W must be at least 1");
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (dec && cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign zero = (cnt_q == '0);

endmodule : ebt_wait_cnt

`default_nettype wire
